// ==== src/line_unit_pkg.sv ====
package line_unit_pkg;
  localparam int unsigned LINE_COUNT = 23;
  localparam int unsigned PIN_LINES = 16;
  localparam int unsigned INTERNAL_LINES = 7;
  localparam int unsigned ADDR_WIDTH = 6;
  localparam int unsigned DATA_WIDTH = 32;
  localparam int unsigned INDEX_WIDTH = 3;
  localparam int unsigned INDEX_LSB = 2;
  localparam int unsigned BE_WIDTH = 4;
  localparam int unsigned PORT_SEL_WIDTH = 2;
  localparam int unsigned LINES_PER_SEL_REG = 8;

  typedef logic [LINE_COUNT-1:0] line_vec_t;
  typedef logic [PIN_LINES-1:0] pin_vec_t;
  typedef logic [INTERNAL_LINES-1:0] wake_vec_t;
  typedef logic [ADDR_WIDTH-1:0] addr_t;
  typedef logic [DATA_WIDTH-1:0] word_t;
  typedef logic [INDEX_WIDTH-1:0] index_t;
  typedef logic [BE_WIDTH-1:0] be_t;
  typedef logic [PORT_SEL_WIDTH-1:0] port_sel_t;

  // Byte offsets of the word registers
  localparam addr_t OFS_IRQ_ENABLE = 6'h00;
  localparam addr_t OFS_EVENT_ENABLE = 6'h04;
  localparam addr_t OFS_RISING_SELECT = 6'h08;
  localparam addr_t OFS_FALLING_SELECT = 6'h0C;
  localparam addr_t OFS_SOFT_TRIGGER = 6'h10;
  localparam addr_t OFS_PENDING = 6'h14;
  localparam addr_t OFS_PORT_SEL_LOW = 6'h18;
  localparam addr_t OFS_PORT_SEL_HIGH = 6'h1C;
  // Addresses at or above this read zero and ignore writes
  localparam addr_t MAP_SPAN = 6'h20;

  localparam index_t IDX_IRQ_ENABLE = index_t'(OFS_IRQ_ENABLE >> INDEX_LSB);
  localparam index_t IDX_EVENT_ENABLE = index_t'(OFS_EVENT_ENABLE >> INDEX_LSB);
  localparam index_t IDX_RISING_SELECT = index_t'(OFS_RISING_SELECT >> INDEX_LSB);
  localparam index_t IDX_FALLING_SELECT = index_t'(OFS_FALLING_SELECT >> INDEX_LSB);
  localparam index_t IDX_SOFT_TRIGGER = index_t'(OFS_SOFT_TRIGGER >> INDEX_LSB);
  localparam index_t IDX_PENDING = index_t'(OFS_PENDING >> INDEX_LSB);
  localparam index_t IDX_PORT_SEL_LOW = index_t'(OFS_PORT_SEL_LOW >> INDEX_LSB);
  localparam index_t IDX_PORT_SEL_HIGH = index_t'(OFS_PORT_SEL_HIGH >> INDEX_LSB);

  localparam line_vec_t LINE_RESET = 23'h000000;
  localparam word_t WORD_ZERO = 32'h00000000;
  localparam be_t FULL_WORD_BE = 4'hF;

  // Port codes for pin-sourced lines
  localparam port_sel_t PORT_A = 2'h0;
  localparam port_sel_t PORT_B = 2'h1;
  localparam port_sel_t PORT_C = 2'h2;
  localparam port_sel_t PORT_NONE = 2'h3;

  typedef struct packed {
    logic read;
    logic write;
    addr_t address;
    word_t writedata;
    be_t byteenable;
  } bus_req_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic mapped;
    index_t index;
    word_t wdata;
  } reg_access_t;

  typedef struct packed {
    pin_vec_t a;
    pin_vec_t b;
    pin_vec_t c;
  } pin_ports_t;

  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;
endpackage : line_unit_pkg

// ==== src/line_edge_detect.sv ====
module line_edge_detect (
  input wire logic mclk,
  input wire logic reset_n,
  input wire line_unit_pkg::line_vec_t raw,
  output line_unit_pkg::line_vec_t rise,
  output line_unit_pkg::line_vec_t fall
);
  import line_unit_pkg::*;

  typedef struct packed {
    line_vec_t meta;
    line_vec_t sync;
    line_vec_t last;
  } edge_state_t;

  localparam edge_state_t EDGE_RESET = '{LINE_RESET, LINE_RESET, LINE_RESET};

  edge_state_t st;
  edge_state_t next_st;

  // Meta stage feeds only the sync stage
  always_comb begin
    next_st = st;
    next_st.meta = raw;
    next_st.sync = st.meta;
    next_st.last = st.sync;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st <= EDGE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rise = st.sync & ~st.last;
  assign fall = ~st.sync & st.last;
endmodule : line_edge_detect

// ==== src/bus_word_slave.sv ====
module bus_word_slave (
  input wire logic mclk,
  input wire logic reset_n,
  input wire line_unit_pkg::bus_req_t req,
  input wire line_unit_pkg::word_t read_value,
  output logic waitrequest,
  output line_unit_pkg::word_t readdata,
  output line_unit_pkg::reg_access_t access
);
  import line_unit_pkg::*;

  typedef struct packed {
    bus_state_t phase;
    word_t readdata;
  } slave_state_t;

  localparam slave_state_t SLAVE_RESET = '{BUS_IDLE, WORD_ZERO};

  slave_state_t st;
  slave_state_t next_st;
  logic active;

  assign active = req.read || req.write;

  // One wait cycle, then the answer; write lands on the releasing edge
  always_comb begin
    next_st = st;
    access.wr = 1'b0;
    access.rd = 1'b0;
    access.mapped = req.address < MAP_SPAN;
    access.index = req.address[INDEX_LSB +: INDEX_WIDTH];
    access.wdata = req.writedata;
    unique case (st.phase)
      BUS_IDLE: begin
        if (active) begin
          next_st.phase = BUS_ANSWER;
          // A write must not disturb the last word read
          if (req.read) begin
            next_st.readdata = read_value;
          end
        end
      end
      BUS_ANSWER: begin
        next_st.phase = BUS_IDLE;
        // Partial words are ignored rather than merged
        access.wr = req.write && (req.byteenable == FULL_WORD_BE);
        access.rd = req.read;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st <= SLAVE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign waitrequest = active && (st.phase != BUS_ANSWER);
  assign readdata = st.readdata;
endmodule : bus_word_slave

// ==== src/external_line_unit.sv ====
// How it works
// - Twenty-three lines, each raising interrupt or event.
// - Source is a pin or seven internal wakes.
// - One port pin per pin line, never merged.
// - Rising, falling or both edges per line.
// - Rising select enables rising edge triggers.
// - Soft trigger bit fires the line directly.
// - Interrupt enable gates interrupt requests per line.
// - Event enable gates event pulses per line.
// - Pending bit readable, cleared by writing one.
// - Clearing pending also clears soft trigger bit.
// - Bits 31 to 23 always read zero.
// - Falling select enables falling edge triggers.
// - Soft trigger sets pending and emits event, each only where its enable is set.
module external_line_unit (
  input wire logic mclk,
  input wire logic reset_n,
  input wire line_unit_pkg::addr_t avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire line_unit_pkg::word_t avs_writedata,
  input wire line_unit_pkg::be_t avs_byteenable,
  output line_unit_pkg::word_t avs_readdata,
  output logic avs_waitrequest,
  input wire line_unit_pkg::pin_vec_t port_a_pins,
  input wire line_unit_pkg::pin_vec_t port_b_pins,
  input wire line_unit_pkg::pin_vec_t port_c_pins,
  input wire line_unit_pkg::wake_vec_t internal_wake,
  output line_unit_pkg::line_vec_t irq_request,
  output logic irq_any,
  output line_unit_pkg::line_vec_t event_pulse
);
  import line_unit_pkg::*;

  typedef struct packed {
    line_vec_t irq_enable;
    line_vec_t event_enable;
    line_vec_t rising_select;
    line_vec_t falling_select;
    line_vec_t soft_trigger;
    line_vec_t pending;
    logic [PIN_LINES-1:0][PORT_SEL_WIDTH-1:0] port_sel;
    line_vec_t irq_request;
    logic irq_any;
    line_vec_t event_pulse;
  } unit_state_t;

  localparam unit_state_t UNIT_RESET = '0;

  unit_state_t st;
  unit_state_t next_st;
  bus_req_t req;
  reg_access_t access;
  word_t read_value;
  line_vec_t line_source;
  line_vec_t rise;
  line_vec_t fall;
  line_vec_t edge_trig;
  line_vec_t soft_fire;
  line_vec_t clear_mask;
  line_vec_t line_trig;
  pin_ports_t pins;

  // Only the one selected port reaches the line
  function automatic logic pick_pin(input port_sel_t sel, input logic a, input logic b,
                                    input logic c);
    logic bit_out;
    unique case (sel)
      PORT_A: bit_out = a;
      PORT_B: bit_out = b;
      PORT_C: bit_out = c;
      PORT_NONE: bit_out = 1'b0;
    endcase
    return bit_out;
  endfunction : pick_pin

  function automatic logic reg_write(input reg_access_t acc, input index_t idx);
    return acc.wr && acc.mapped && (acc.index == idx);
  endfunction : reg_write

  // Upper bits of a written word are dropped
  function automatic line_vec_t word_lines(input word_t w);
    return w[LINE_COUNT-1:0];
  endfunction : word_lines

  function automatic word_t pack_sel(input logic [PIN_LINES-1:0][PORT_SEL_WIDTH-1:0] sel,
                                     input int unsigned half);
    word_t w;
    w = WORD_ZERO;
    for (int j = 0; j < LINES_PER_SEL_REG; j++) begin
      w[j*PORT_SEL_WIDTH +: PORT_SEL_WIDTH] = sel[half*LINES_PER_SEL_REG + j];
    end
    return w;
  endfunction : pack_sel

  assign req = '{avs_read, avs_write, avs_address, avs_writedata, avs_byteenable};
  assign pins = '{port_a_pins, port_b_pins, port_c_pins};

  bus_word_slave u_slave (
    .mclk(mclk),
    .reset_n(reset_n),
    .req(req),
    .read_value(read_value),
    .waitrequest(avs_waitrequest),
    .readdata(avs_readdata),
    .access(access)
  );

  for (genvar i = 0; i < PIN_LINES; i++) begin : g_pin_line
    assign line_source[i] = pick_pin(st.port_sel[i], pins.a[i], pins.b[i], pins.c[i]);
  end

  assign line_source[LINE_COUNT-1:PIN_LINES] = internal_wake;

  line_edge_detect u_edge (
    .mclk(mclk),
    .reset_n(reset_n),
    .raw(line_source),
    .rise(rise),
    .fall(fall)
  );

  always_comb begin
    read_value = WORD_ZERO;
    if (access.mapped) begin
      unique case (access.index)
        IDX_IRQ_ENABLE: read_value = word_t'(st.irq_enable);
        IDX_EVENT_ENABLE: read_value = word_t'(st.event_enable);
        IDX_RISING_SELECT: read_value = word_t'(st.rising_select);
        IDX_FALLING_SELECT: read_value = word_t'(st.falling_select);
        IDX_SOFT_TRIGGER: read_value = word_t'(st.soft_trigger);
        IDX_PENDING: read_value = word_t'(st.pending);
        IDX_PORT_SEL_LOW: read_value = pack_sel(st.port_sel, 0);
        IDX_PORT_SEL_HIGH: read_value = pack_sel(st.port_sel, 1);
      endcase
    end
  end

  always_comb begin
    next_st = st;
    if (reg_write(access, IDX_IRQ_ENABLE)) begin
      next_st.irq_enable = word_lines(access.wdata);
    end
    if (reg_write(access, IDX_EVENT_ENABLE)) begin
      next_st.event_enable = word_lines(access.wdata);
    end
    if (reg_write(access, IDX_RISING_SELECT)) begin
      next_st.rising_select = word_lines(access.wdata);
    end
    if (reg_write(access, IDX_FALLING_SELECT)) begin
      next_st.falling_select = word_lines(access.wdata);
    end
    for (int j = 0; j < LINES_PER_SEL_REG; j++) begin
      if (reg_write(access, IDX_PORT_SEL_LOW)) begin
        next_st.port_sel[j] = access.wdata[j*PORT_SEL_WIDTH +: PORT_SEL_WIDTH];
      end
      if (reg_write(access, IDX_PORT_SEL_HIGH)) begin
        next_st.port_sel[LINES_PER_SEL_REG + j] =
          access.wdata[j*PORT_SEL_WIDTH +: PORT_SEL_WIDTH];
      end
    end

    edge_trig = (rise & st.rising_select) | (fall & st.falling_select);

    // a newly set soft bit fires once
    soft_fire = reg_write(access, IDX_SOFT_TRIGGER) ?
                (word_lines(access.wdata) & ~st.soft_trigger) : LINE_RESET;
    clear_mask = reg_write(access, IDX_PENDING) ? word_lines(access.wdata) : LINE_RESET;
    // edge or software trigger per line
    line_trig = edge_trig | soft_fire;

    next_st.soft_trigger = (reg_write(access, IDX_SOFT_TRIGGER) ?
                            word_lines(access.wdata) : st.soft_trigger) & ~clear_mask;
    next_st.pending = (st.pending & ~clear_mask) | (line_trig & st.irq_enable);

    next_st.event_pulse = line_trig & st.event_enable;
    next_st.irq_request = next_st.pending & next_st.irq_enable;
    next_st.irq_any = |next_st.irq_request;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st <= UNIT_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign irq_request = st.irq_request;
  assign irq_any = st.irq_any;
  assign event_pulse = st.event_pulse;
endmodule : external_line_unit

// ==== verification/line_unit_asserts.sv ====
module line_unit_asserts (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire line_unit_pkg::word_t avs_readdata,
  input wire logic avs_waitrequest,
  input wire line_unit_pkg::pin_vec_t port_a_pins,
  input wire line_unit_pkg::wake_vec_t internal_wake,
  input wire line_unit_pkg::line_vec_t irq_request,
  input wire logic irq_any,
  input wire line_unit_pkg::line_vec_t event_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  import line_unit_pkg::*;
  logic [22:0] src_q;
  logic [5:0] hist;
  wire logic req = avs_read | avs_write;
  wire logic done = req & ~avs_waitrequest;
  // Only port A and wakes count, so B and C noise is no cause
  always_ff @(posedge mclk) begin
    src_q <= {internal_wake, port_a_pins};
    hist <= reset_n ? {hist[4:0], done | ({internal_wake, port_a_pins} != src_q)} : 6'h3F;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  sequence s_held;
    req && avs_waitrequest;
  endsequence
  sequence s_evt;
    event_pulse != 23'h000000;
  endsequence
  a_wait_once: assert property (s_held |=> !avs_waitrequest)
    else $error("wait state too long");
  a_idle_ready: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest while idle");
  a_high_zero: assert property (done && avs_read |-> avs_readdata[31:23] == 9'h000)
    else $error("upper read bits set");
  a_data_kept: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved");
  a_any_or: assert property (irq_any == (|irq_request))
    else $error("summary request wrong");
  a_irq_kept: assert property ((($past(irq_request) & ~irq_request) != 0) |-> $past(done))
    else $error("request dropped alone");
  a_irq_cause: assert property (((irq_request & ~$past(irq_request)) != 0) |-> hist != 0)
    else $error("request without cause");
  a_event_cause: assert property (s_evt |-> hist != 6'h00)
    else $error("event without cause");
  a_event_pulse: assert property (s_evt |=> (event_pulse & $past(event_pulse)) == 0)
    else $error("event longer than a cycle");
endmodule : line_unit_asserts

bind external_line_unit line_unit_asserts chk_u (.mclk, .reset_n, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .port_a_pins, .internal_wake, .irq_request, .irq_any,
  .event_pulse);

// ==== verification/line_source_model.sv ====
module line_source_model (
  input wire logic mclk,
  input wire line_unit_pkg::line_vec_t level,
  output line_unit_pkg::pin_vec_t port_a_pins,
  output line_unit_pkg::pin_vec_t port_b_pins,
  output line_unit_pkg::pin_vec_t port_c_pins,
  output line_unit_pkg::wake_vec_t internal_wake
);
  timeunit 1ns;
  timeprecision 1ps;
  import line_unit_pkg::*;
  assign port_a_pins = level[15:0];
  assign internal_wake = level[22:16];
  // Unselected ports toggle, they must never reach a line
  always @(posedge mclk) begin
    port_b_pins <= 16'($urandom);
    port_c_pins <= 16'($urandom);
  end
endmodule : line_source_model

// ==== verification/external_line_unit_test.sv ====
module external_line_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  import line_unit_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  addr_t avs_address = 6'h00;
  word_t avs_writedata = 32'h00000000;
  be_t avs_byteenable = 4'hF;
  word_t avs_readdata;
  logic avs_waitrequest;
  pin_vec_t port_a_pins, port_b_pins, port_c_pins;
  wake_vec_t internal_wake;
  line_vec_t irq_request, event_pulse;
  logic irq_any;
  line_vec_t level = 23'h000000;
  word_t ie, ee, rs, fs, sw, pend, ev, ps0, ps1;
  addr_t order [5] = '{6'h08, 6'h0C, 6'h00, 6'h04, 6'h10};
  int n_errors = 0;
  int n_compared = 0;
  always #12.5 mclk = ~mclk;
  external_line_unit dut_u (.mclk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .port_a_pins,
    .port_b_pins, .port_c_pins, .internal_wake, .irq_request, .irq_any, .event_pulse);
  line_source_model src_u (.mclk, .level, .port_a_pins, .port_b_pins, .port_c_pins,
    .internal_wake);
  task automatic check(input word_t seen, input word_t exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input addr_t a, input word_t d, input be_t be,
    output word_t q);
    @(posedge mclk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    // Pre-edge values are seen here, so a low waitrequest ends the transfer
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic outs;
    check(word_t'(event_pulse), ev);
    check(word_t'(irq_request), pend & ie);
    check(word_t'(irq_any), word_t'(|(pend & ie)));
  endtask : outs
  task automatic wr(input addr_t a, input word_t d, input be_t be = 4'hF,
    input word_t hit = 32'h00000000);
    word_t q;
    word_t v;
    v = d & 32'h007FFFFF;
    ev = 32'h00000000;
    bus(1'b1, a, d, be, q);
    if (be == 4'hF) begin
      case (a)
        6'h00: ie = v;
        6'h04: ee = v;
        6'h08: rs = v;
        6'h0C: fs = v;
        6'h10: begin
          ev = v & ~sw & ee;
          pend |= v & ~sw & ie;
          sw = v;
        end
        6'h14: begin
          pend &= ~v;
          sw &= ~v;
        end
        6'h18: ps0 = d & 32'h0000FFFF;
        6'h1C: ps1 = d & 32'h0000FFFF;
        default: ;
      endcase
    end
    pend |= hit & ie;
    ev |= hit & ee;
    #1;
    outs();
  endtask : wr
  task automatic rd(input addr_t a);
    word_t q;
    word_t e;
    bus(1'b0, a, 32'h00000000, 4'hF, q);
    case (a)
      6'h00: e = ie;
      6'h04: e = ee;
      6'h08: e = rs;
      6'h0C: e = fs;
      6'h10: e = sw;
      6'h14: e = pend;
      6'h18: e = ps0;
      6'h1C: e = ps1;
      default: e = 32'h00000000;
    endcase
    check(q, e);
  endtask : rd
  task automatic lines(input line_vec_t nv, input logic race);
    word_t t;
    t = (word_t'(nv) & ~word_t'(level) & rs) | (~word_t'(nv) & word_t'(level) & fs);
    @(posedge mclk);
    level <= nv;
    if (race) begin
      wr(6'h14, 32'h007FFFFF, 4'hF, t);
    end else begin
      repeat (3) @(posedge mclk);
      #1;
      ev = t & ee;
      pend |= t & ie;
      outs();
    end
    @(posedge mclk);
    #1;
    ev = 32'h00000000;
    outs();
  endtask : lines
  initial begin
    {ie, ee, rs, fs, sw, pend, ev, ps0, ps1} = '0;
    void'($urandom(21872));
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    for (int a = 0; a < 48; a += 4) begin
      rd(addr_t'(a));
    end
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      foreach (order[k]) begin
        wr(order[k], $urandom);
      end
      wr(6'h14, 32'h00000000);
      for (int a = 0; a < 24; a += 4) begin
        rd(addr_t'(a));
      end
      wr(6'h14, $urandom);
      rd(6'h10);
      rd(6'h14);
    end
    $display("test registers and soft trigger done");
    for (int i = 0; i < 24; i++) begin
      lines(line_vec_t'($urandom), i[0]);
    end
    $display("test edges done");
    wr(6'h00, 32'hFFFFFFFF, 4'h3);
    rd(6'h00);
    wr(6'h24, 32'hFFFFFFFF);
    rd(6'h24);
    wr(6'h00, 32'h00000000);
    rd(6'h14);
    $display("test refusals done");
    wr(6'h04, 32'h00000000);
    wr(6'h18, 32'hFFFFFFFF);
    wr(6'h1C, 32'h5555AAAA);
    rd(6'h18);
    rd(6'h1C);
    $display("test port select done");
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    {ie, ee, rs, fs, sw, pend, ev, ps0, ps1} = '0;
    for (int a = 0; a < 32; a += 4) begin
      rd(addr_t'(a));
    end
    $display("test mid-run reset done");
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    print_verdict();
  end
endmodule : external_line_unit_test
